// ===== ata_cmd_pkg.sv
// Package with task file constants, command codes and carrier types for the command decoder.
package ata_cmd_pkg;

	// ------------------------------------------------------------------
	// Task file register selects
	// ------------------------------------------------------------------
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_FEATURE = 3'h1;
	localparam logic [2:0] REG_COUNT = 3'h2;
	localparam logic [2:0] REG_LBA_LOW = 3'h3;
	localparam logic [2:0] REG_LBA_MID = 3'h4;
	localparam logic [2:0] REG_LBA_HIGH = 3'h5;
	localparam logic [2:0] REG_DRIVE_HEAD = 3'h6;
	localparam logic [2:0] REG_COMMAND = 3'h7;

	// ------------------------------------------------------------------
	// Command and feature codes
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_WRITE_SECTORS = 8'h30;
	localparam logic [7:0] CMD_WRITE_SECTORS_ALT = 8'h31;
	localparam logic [7:0] CMD_WRITE_NO_ERASE = 8'h38;
	localparam logic [7:0] CMD_WRITE_VERIFY = 8'h3c;
	localparam logic [7:0] CMD_SMART = 8'hb0;
	localparam logic [7:0] FEAT_READ_DATA = 8'hd0;
	localparam logic [7:0] FEAT_READ_THRESH = 8'hd1;
	localparam logic [7:0] FEAT_AUTOSAVE = 8'hd2;
	localparam logic [7:0] FEAT_ENABLE = 8'hd8;
	localparam logic [7:0] FEAT_DISABLE = 8'hd9;
	localparam logic [7:0] FEAT_STATUS = 8'hda;
	localparam logic [7:0] AUTOSAVE_COUNT_OFF = 8'h00;
	localparam logic [7:0] AUTOSAVE_COUNT_ON = 8'hf1;
	localparam logic [7:0] SMART_KEY_HIGH = 8'hc2;
	localparam logic [7:0] SMART_KEY_MID = 8'h4f;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int DH_LBA_BIT = 6;
	localparam int DH_DRIVE_BIT = 4;
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_READY_BIT = 6;
	localparam int ST_DRQ_BIT = 3;
	localparam int ST_ERR_BIT = 0;
	localparam int ERR_ABORT_BIT = 2;
	localparam logic [7:0] DRIVE_HEAD_RESET = 8'ha0;
	localparam logic [7:0] COUNT_RESET = 8'h01;
	localparam logic [7:0] LBA_LOW_RESET = 8'h01;
	localparam logic [8:0] FULL_COUNT = 9'h100;
	localparam int WORDS_PER_SECTOR = 256;
	localparam int FIFO_DEPTH = 8;

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [15:0] data;
	} host_access_type;

	typedef struct packed {
		logic [27:0] lba;
		logic verify;
		logic no_erase;
	} flash_req_type;

endpackage : ata_cmd_pkg

// ===== sector_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides.
module sector_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic flush_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_out = (count_reg != '0);
	assign out_data_out = mem[rd_ptr_reg];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	// Storage array is written without reset to keep it as plain memory.
	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_in;
		end
	end

	// Pointers wrap at the depth; flush drops anything left from an aborted sector.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (flush_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : sector_fifo

// ===== ata_write_smart.sv
// Task file command decoder for no-erase write, write-verify and SMART commands.
module ata_write_smart #(
	parameter int DATA_W = 16,
	parameter int FIFO_DEPTH = ata_cmd_pkg::FIFO_DEPTH,
	parameter int SECTOR_WORDS = ata_cmd_pkg::WORDS_PER_SECTOR
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Host task file port.
	input wire ata_cmd_pkg::host_access_type host_in,
	output logic [15:0] host_rdata_out,
	output logic host_irq_out,
	// Flash side: requests, data and results.
	output logic flash_req_valid_out,
	output ata_cmd_pkg::flash_req_type flash_req_out,
	input wire logic flash_req_ready_in,
	output logic flash_data_valid_out,
	input wire logic flash_data_ready_in,
	output logic [DATA_W-1:0] flash_data_out,
	input wire logic flash_done_in,
	input wire logic flash_error_in,
	// SMART read source and nonvolatile enable storage.
	input wire logic [DATA_W-1:0] smart_data_in,
	input wire logic nv_smart_en_in,
	input wire logic nv_valid_in,
	output logic nv_write_out,
	output logic nv_smart_en_out
);
	localparam int CW = $clog2(SECTOR_WORDS) + 1;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ACCEPT = 5'b00010,
		ST_FILL = 5'b00100,
		ST_PROGRAM = 5'b01000,
		ST_SEND = 5'b10000
	} state_type;

	// ------------------------------------------------------------------
	// Reset release and registers
	// ------------------------------------------------------------------
	logic rst_sync1_reg;
	logic rst_sync2_reg;
	logic rst_n;
	state_type state_reg;
	logic [7:0] feature_select_reg;
	logic [7:0] transfer_sector_count_reg;
	logic [7:0] lba_low_byte_reg;
	logic [7:0] lba_mid_byte_reg;
	logic [7:0] lba_high_byte_reg;
	logic [7:0] drive_head_select_reg;
	logic busy_reg;
	logic drq_reg;
	logic err_reg;
	logic abort_reg;
	logic irq_reg;
	logic smart_en_reg;
	logic nv_loaded_reg;
	logic nv_write_reg;
	logic verify_reg;
	logic no_erase_reg;
	logic [8:0] remain_reg;
	logic [CW-1:0] word_cnt_reg;
	logic req_valid_reg;
	logic [15:0] rdata_reg;

	logic cmd_wr;
	logic [7:0] cmd_code;
	logic is_write_cmd;
	logic is_smart_cmd;
	logic feature_ok;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic data_wr;
	logic [27:0] cur_lba;
	logic [27:0] next_lba;
	logic [7:0] status_byte;
	logic last_word;
	logic cmd_refused;
	logic data_rd;

	// The release is synchronised so every flop behind the two-stage synchroniser leaves reset on the same edge.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end
	assign rst_n = rst_sync2_reg;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	// Commands are taken only while idle; later writes are ignored.
	assign cmd_code = host_in.data[7:0];
	assign cmd_wr = host_in.wr && host_in.addr == ata_cmd_pkg::REG_COMMAND
		&& state_reg == ST_IDLE;
	assign is_write_cmd = cmd_code == ata_cmd_pkg::CMD_WRITE_SECTORS
		|| cmd_code == ata_cmd_pkg::CMD_WRITE_SECTORS_ALT
		|| cmd_code == ata_cmd_pkg::CMD_WRITE_NO_ERASE
		|| cmd_code == ata_cmd_pkg::CMD_WRITE_VERIFY;
	assign is_smart_cmd = cmd_code == ata_cmd_pkg::CMD_SMART;
	assign cmd_refused = !is_write_cmd && !(is_smart_cmd && feature_ok
		&& (smart_en_reg || feature_select_reg == ata_cmd_pkg::FEAT_ENABLE));
	assign data_rd = host_in.rd && host_in.addr == ata_cmd_pkg::REG_DATA;

	// Six feature values are recognised; every other feature value aborts.
	always_comb begin
		unique case (feature_select_reg)
			ata_cmd_pkg::FEAT_READ_DATA,
			ata_cmd_pkg::FEAT_READ_THRESH,
			ata_cmd_pkg::FEAT_AUTOSAVE,
			ata_cmd_pkg::FEAT_ENABLE,
			ata_cmd_pkg::FEAT_DISABLE,
			ata_cmd_pkg::FEAT_STATUS: feature_ok = 1'b1;
			default: feature_ok = 1'b0;
		endcase
	end

	// Address assembly: head nibble, then high, mid and low bytes.
	assign cur_lba = {drive_head_select_reg[3:0], lba_high_byte_reg,
		lba_mid_byte_reg, lba_low_byte_reg};
	assign next_lba = cur_lba + 28'h0000001;
	assign data_wr = host_in.wr && host_in.addr == ata_cmd_pkg::REG_DATA;
	assign fifo_in_valid = data_wr && state_reg == ST_FILL && drq_reg;
	assign last_word = word_cnt_reg == CW'(SECTOR_WORDS - 1);

	// ------------------------------------------------------------------
	// Data path buffer
	// ------------------------------------------------------------------
	sector_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n),
		.flush_in(cmd_wr),
		.in_valid_in(fifo_in_valid),
		.in_ready_out(fifo_in_ready),
		.in_data_in(host_in.data[DATA_W-1:0]),
		.out_valid_out(flash_data_valid_out),
		.out_ready_in(flash_data_ready_in),
		.out_data_out(flash_data_out)
	);

	// ------------------------------------------------------------------
	// Task file registers
	// ------------------------------------------------------------------
	// Host writes load the block; the device advances the address per good sector.
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			feature_select_reg <= 8'h00;
			transfer_sector_count_reg <= ata_cmd_pkg::COUNT_RESET;
			lba_low_byte_reg <= ata_cmd_pkg::LBA_LOW_RESET;
			lba_mid_byte_reg <= 8'h00;
			lba_high_byte_reg <= 8'h00;
			drive_head_select_reg <= ata_cmd_pkg::DRIVE_HEAD_RESET;
		end else if (state_reg == ST_PROGRAM && flash_done_in && !flash_error_in) begin
			// A failed sector leaves its own address in place for the host.
			lba_low_byte_reg <= next_lba[7:0];
			lba_mid_byte_reg <= next_lba[15:8];
			lba_high_byte_reg <= next_lba[23:16];
			drive_head_select_reg[3:0] <= next_lba[27:24];
			transfer_sector_count_reg <= transfer_sector_count_reg - 8'h01;
		end else if (host_in.wr && state_reg == ST_IDLE) begin
			unique case (host_in.addr)
				ata_cmd_pkg::REG_FEATURE: feature_select_reg <= host_in.data[7:0];
				ata_cmd_pkg::REG_COUNT: transfer_sector_count_reg <= host_in.data[7:0];
				ata_cmd_pkg::REG_LBA_LOW: lba_low_byte_reg <= host_in.data[7:0];
				ata_cmd_pkg::REG_LBA_MID: lba_mid_byte_reg <= host_in.data[7:0];
				ata_cmd_pkg::REG_LBA_HIGH: lba_high_byte_reg <= host_in.data[7:0];
				ata_cmd_pkg::REG_DRIVE_HEAD: drive_head_select_reg <= host_in.data[7:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------------
	// Busy, data request and completion follow the ordinary write handshake.
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			busy_reg <= 1'b0;
			drq_reg <= 1'b0;
			remain_reg <= 9'h000;
			verify_reg <= 1'b0;
			no_erase_reg <= 1'b0;
			req_valid_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (cmd_wr && is_write_cmd) begin
						busy_reg <= 1'b1;
						// Zero requests the full 256 sectors.
						remain_reg <= (transfer_sector_count_reg == 8'h00)
							? ata_cmd_pkg::FULL_COUNT : {1'b0, transfer_sector_count_reg};
						verify_reg <= cmd_code == ata_cmd_pkg::CMD_WRITE_VERIFY;
						no_erase_reg <= cmd_code == ata_cmd_pkg::CMD_WRITE_NO_ERASE;
						state_reg <= ST_ACCEPT;
					end else if (cmd_wr && is_smart_cmd && feature_ok && smart_en_reg
						&& feature_select_reg == ata_cmd_pkg::FEAT_READ_DATA) begin
						busy_reg <= 1'b1;
						state_reg <= ST_SEND;
					end
				end
				ST_ACCEPT: begin
					busy_reg <= 1'b0;
					drq_reg <= 1'b1;
					state_reg <= ST_FILL;
				end
				ST_FILL: begin
					if (fifo_in_valid && fifo_in_ready && last_word) begin
						drq_reg <= 1'b0;
						busy_reg <= 1'b1;
						req_valid_reg <= 1'b1;
						state_reg <= ST_PROGRAM;
					end
				end
				ST_PROGRAM: begin
					if (req_valid_reg && flash_req_ready_in) begin
						req_valid_reg <= 1'b0;
					end
					// Erased or not, the flash side writes the sector; only a true fault or the last sector ends.
					if (flash_done_in) begin
						remain_reg <= remain_reg - 9'h001;
						if (flash_error_in || remain_reg == 9'h001) begin
							busy_reg <= 1'b0;
							state_reg <= ST_IDLE;
						end else begin
							busy_reg <= 1'b0;
							drq_reg <= 1'b1;
							state_reg <= ST_FILL;
						end
					end
				end
				ST_SEND: begin
					busy_reg <= 1'b0;
					drq_reg <= !(data_rd && drq_reg && last_word);
					if (drq_reg && data_rd && last_word) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Word counter shared by host-to-flash fill and the one-sector SMART read.
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			word_cnt_reg <= '0;
		end else if (cmd_wr) begin
			word_cnt_reg <= '0;
		end else if ((state_reg == ST_FILL && fifo_in_valid && fifo_in_ready)
			|| (state_reg == ST_SEND && drq_reg && data_rd)) begin
			word_cnt_reg <= last_word ? '0 : word_cnt_reg + 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Error, interrupt and SMART state
	// ------------------------------------------------------------------
	// Abort covers bad features, SMART while disabled and unknown opcodes.
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			err_reg <= 1'b0;
			abort_reg <= 1'b0;
		end else if (cmd_wr) begin
			abort_reg <= cmd_refused;
			err_reg <= cmd_refused;
		end else if (state_reg == ST_PROGRAM && flash_done_in && flash_error_in) begin
			err_reg <= 1'b1;
		end
	end

	// Interrupt pulses when a sector ends and on abort, never at command start.
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (state_reg == ST_PROGRAM && flash_done_in)
				|| (cmd_wr && cmd_refused);
		end
	end

	// Enable state is loaded from nonvolatile storage once and written back on every enable and on a disable that clears it.
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			smart_en_reg <= 1'b0;
			nv_loaded_reg <= 1'b0;
			nv_write_reg <= 1'b0;
		end else begin
			nv_write_reg <= 1'b0;
			if (!nv_loaded_reg && nv_valid_in) begin
				smart_en_reg <= nv_smart_en_in;
				nv_loaded_reg <= 1'b1;
			end else if (cmd_wr && is_smart_cmd) begin
				// Autosave is accepted and changes nothing: data is always current.
				if (feature_select_reg == ata_cmd_pkg::FEAT_ENABLE) begin
					smart_en_reg <= 1'b1;
					nv_write_reg <= 1'b1;
				end else if (feature_select_reg == ata_cmd_pkg::FEAT_DISABLE && smart_en_reg) begin
					smart_en_reg <= 1'b0;
					nv_write_reg <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Read-back and outputs
	// ------------------------------------------------------------------
	assign status_byte = {busy_reg, !busy_reg, 2'b00, drq_reg, 2'b00, err_reg};

	// Registered read data so the host port never sees a combinational path.
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 16'h0000;
		end else if (host_in.rd) begin
			unique case (host_in.addr)
				ata_cmd_pkg::REG_DATA: rdata_reg <= 16'(smart_data_in);
				ata_cmd_pkg::REG_FEATURE: rdata_reg <= {8'h00, 5'h00, abort_reg, 2'b00};
				ata_cmd_pkg::REG_COUNT: rdata_reg <= {8'h00, transfer_sector_count_reg};
				ata_cmd_pkg::REG_LBA_LOW: rdata_reg <= {8'h00, lba_low_byte_reg};
				ata_cmd_pkg::REG_LBA_MID: rdata_reg <= {8'h00, lba_mid_byte_reg};
				ata_cmd_pkg::REG_LBA_HIGH: rdata_reg <= {8'h00, lba_high_byte_reg};
				ata_cmd_pkg::REG_DRIVE_HEAD: rdata_reg <= {8'h00, drive_head_select_reg};
				ata_cmd_pkg::REG_COMMAND: rdata_reg <= {8'h00, status_byte};
				default: rdata_reg <= 16'h0000;
			endcase
		end
	end

	assign host_rdata_out = rdata_reg;
	assign host_irq_out = irq_reg;
	assign flash_req_valid_out = req_valid_reg;
	assign flash_req_out = '{lba: cur_lba, verify: verify_reg, no_erase: no_erase_reg};
	assign nv_write_out = nv_write_reg;
	assign nv_smart_en_out = smart_en_reg;

endmodule : ata_write_smart

// ===== ata_write_smart_asserts.sv
// Port checks for the task file command decoder.
module ata_write_smart_asserts #(
	parameter int DATA_W = 16
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire ata_cmd_pkg::host_access_type host_in,
	input wire logic host_irq_out,
	input wire logic flash_req_valid_out,
	input wire ata_cmd_pkg::flash_req_type flash_req_out,
	input wire logic flash_req_ready_in,
	input wire logic flash_data_valid_out,
	input wire logic flash_data_ready_in,
	input wire logic [DATA_W-1:0] flash_data_out,
	input wire logic flash_done_in,
	input wire logic nv_write_out,
	input wire logic nv_smart_en_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cmd_reg, feat_reg, dh_reg;
	logic [23:0] lba_reg;
	logic first_reg, cmd_wr, smart_ok;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// ----
	// Shadow of the task file as the host wrote it
	// ----
	assign cmd_wr = host_in.wr && host_in.addr == ata_cmd_pkg::REG_COMMAND;
	assign smart_ok = feat_reg inside {8'hd0, 8'hd1, 8'hd2, 8'hd8, 8'hd9, 8'hda};
	// Hosts load the task file only while idle.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{cmd_reg, feat_reg, dh_reg, lba_reg} <= 48'h0;
		end else if (host_in.wr) begin
			case (host_in.addr)
				3'h1: feat_reg <= host_in.data[7:0];
				3'h3: lba_reg[7:0] <= host_in.data[7:0];
				3'h4: lba_reg[15:8] <= host_in.data[7:0];
				3'h5: lba_reg[23:16] <= host_in.data[7:0];
				3'h6: dh_reg <= host_in.data[7:0];
				3'h7: cmd_reg <= host_in.data[7:0];
				default: ;
			endcase
		end
	end
	// Marks the first sector of a command.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) first_reg <= 1'b0;
		else if (cmd_wr) first_reg <= 1'b1;
		else if (flash_done_in) first_reg <= 1'b0;
	end
	AST_REQ_HOLD: assert property (
		flash_req_valid_out && !flash_req_ready_in |=> flash_req_valid_out && $stable(flash_req_out))
		else $error("request not held");
	AST_FIFO_HOLD: assert property (
		flash_data_valid_out && !flash_data_ready_in |=> flash_data_valid_out && $stable(flash_data_out))
		else $error("data not held");
	AST_NO_ERASE_FLAG: assert property (
		flash_req_valid_out |-> flash_req_out.no_erase == (cmd_reg == 8'h38))
		else $error("no-erase flag wrong");
	AST_VERIFY_FLAG: assert property (
		flash_req_valid_out |-> flash_req_out.verify == (cmd_reg == 8'h3c))
		else $error("verify flag wrong");
	AST_LBA_MAP: assert property (
		$rose(flash_req_valid_out) && first_reg |-> flash_req_out.lba == {dh_reg[3:0], lba_reg})
		else $error("request address wrong");
	AST_IRQ_AFTER_DONE: assert property (
		flash_done_in |-> ##[1:3] host_irq_out)
		else $error("no sector interrupt");
	AST_NO_IRQ_AT_START: assert property (
		cmd_wr && host_in.data[7:0] == 8'h38 |=> !host_irq_out [*3])
		else $error("early interrupt");
	AST_ENABLE_STORE: assert property (
		cmd_wr && host_in.data[7:0] == 8'hb0 && feat_reg == 8'hd8 |-> ##[1:4] nv_write_out && nv_smart_en_out)
		else $error("enable not stored");
	AST_NV_VALUE: assert property (
		nv_write_out |-> nv_smart_en_out == (feat_reg == 8'hd8))
		else $error("stored value wrong");
	AST_AUTOSAVE_QUIET: assert property (
		cmd_wr && host_in.data[7:0] == 8'hb0 && feat_reg == 8'hd2 && nv_smart_en_out
		|=> (!nv_write_out && !flash_req_valid_out && !host_irq_out) [*4])
		else $error("autosave had effect");
	AST_UNSUPPORTED_ABORT: assert property (
		cmd_wr && host_in.data[7:0] == 8'hb0 && !smart_ok |-> ##[1:4] host_irq_out)
		else $error("no abort interrupt");
endmodule : ata_write_smart_asserts

bind ata_write_smart ata_write_smart_asserts #(.DATA_W(DATA_W)) checks (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .host_in(host_in),
	.host_irq_out(host_irq_out), .flash_req_valid_out(flash_req_valid_out),
	.flash_req_out(flash_req_out), .flash_req_ready_in(flash_req_ready_in),
	.flash_data_valid_out(flash_data_valid_out), .flash_data_ready_in(flash_data_ready_in),
	.flash_data_out(flash_data_out), .flash_done_in(flash_done_in),
	.nv_write_out(nv_write_out), .nv_smart_en_out(nv_smart_en_out));

// ===== flash_backend_model.sv
// Behavioural flash back end.
module flash_backend_model (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic req_valid_in,
	input wire ata_cmd_pkg::flash_req_type req_in,
	output logic req_ready_out,
	input wire logic data_valid_in,
	output logic data_ready_out,
	input wire logic [15:0] data_in,
	output logic done_out,
	output logic error_out,
	input wire logic stall_en_in,
	input wire logic [9:0] fail_at_in,
	output logic [9:0] req_count_out,
	output ata_cmd_pkg::flash_req_type last_req_out,
	output logic [31:0] sum_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_reg;
	logic [3:0] phase_reg, delay_reg;
	logic [8:0] words_reg;
	logic pending_reg;
	// Late acceptance makes the request wait.
	assign req_ready_out = req_valid_in && wait_reg == 2'd3;
	// Stall refuses words eight cycles in sixteen.
	assign data_ready_out = !(stall_en_in && phase_reg[3]);
	// Done follows a full sector after a short delay.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{wait_reg, phase_reg, delay_reg, words_reg, pending_reg} <= '0;
			{done_out, error_out, req_count_out, last_req_out, sum_out} <= '0;
		end else begin
			phase_reg <= phase_reg + 4'd1;
			done_out <= 1'b0;
			error_out <= 1'b0;
			if (req_valid_in && !req_ready_out) wait_reg <= wait_reg + 2'd1;
			if (req_ready_out) begin
				wait_reg <= 2'd0;
				pending_reg <= 1'b1;
				req_count_out <= req_count_out + 10'd1;
				last_req_out <= req_in;
				delay_reg <= 4'd5;
			end
			if (data_valid_in && data_ready_out) begin
				words_reg <= words_reg + 9'd1;
				sum_out <= sum_out + 32'(data_in);
			end
			if (pending_reg && words_reg == 9'd256) begin
				if (delay_reg != 4'd0) delay_reg <= delay_reg - 4'd1;
				else begin
					done_out <= 1'b1;
					error_out <= req_count_out == fail_at_in;
					pending_reg <= 1'b0;
					words_reg <= 9'd0;
				end
			end
		end
	end
endmodule : flash_backend_model

// ===== ata_write_and_smart_commands_tb.sv
// Self-checking bench for the task file command decoder.
module ata_write_and_smart_commands_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in, rst_n_in, irq, rv, rr, dv, dr, done, ferr, nv_en, nv_wr, nv_out, stall;
	ata_cmd_pkg::host_access_type host;
	ata_cmd_pkg::flash_req_type req, last;
	logic [15:0] rdata, fdata, v;
	logic [9:0] reqs, fail_at;
	logic [31:0] sum, exp_sum;
	logic [7:0] feats[10] = '{8'h55, 8'hd0, 8'hd8, 8'hd2, 8'hd0, 8'hd1, 8'hda, 8'h07, 8'hd9, 8'hd0};
	logic aborts[10] = '{1, 1, 0, 0, 0, 0, 0, 1, 0, 1};
	int fails, samples_checked, irqs, i0, q0;
	ata_write_smart DUT (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .host_in(host),
		.host_rdata_out(rdata), .host_irq_out(irq), .flash_req_valid_out(rv), .flash_req_out(req),
		.flash_req_ready_in(rr), .flash_data_valid_out(dv), .flash_data_ready_in(dr),
		.flash_data_out(fdata), .flash_done_in(done), .flash_error_in(ferr),
		.smart_data_in(16'h5a3c), .nv_smart_en_in(nv_en), .nv_valid_in(1'b1),
		.nv_write_out(nv_wr), .nv_smart_en_out(nv_out));
	flash_backend_model flash (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .req_valid_in(rv),
		.req_in(req), .req_ready_out(rr), .data_valid_in(dv), .data_ready_out(dr), .data_in(fdata),
		.done_out(done), .error_out(ferr), .stall_en_in(stall), .fail_at_in(fail_at),
		.req_count_out(reqs), .last_req_out(last), .sum_out(sum));
	// ----
	// Clock, interrupt count and watchdog
	// ----
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in) if (irq === 1'b1) irqs++;
	// The full-count run needs about 70000 cycles.
	initial begin
		repeat (90000) @(posedge core_clk_in);
		fails++;
		report_and_stop();
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(negedge core_clk_in) host = '{1'b1, 1'b0, a, d};
		@(negedge core_clk_in) host.wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [15:0] r);
		@(negedge core_clk_in) host = '{1'b0, 1'b1, a, 16'h0000};
		@(negedge core_clk_in) host.rd = 1'b0;
		@(negedge core_clk_in) r = rdata;
	endtask : rd
	task automatic issue(input logic [7:0] code, feat, cnt, dh, hi, mid, lo);
		wr(3'h1, {8'h00, feat});
		wr(3'h2, {8'h00, cnt});
		wr(3'h3, {8'h00, lo});
		wr(3'h4, {8'h00, mid});
		wr(3'h5, {8'h00, hi});
		wr(3'h6, {8'h00, dh});
		wr(3'h7, {8'h00, code});
	endtask : issue
	task automatic wait_status(input logic [7:0] val);
		for (int i = 0; i < 400; i++) begin
			rd(3'h7, v);
			if ((v[7:0] & 8'h88) === val) return;
		end
		check("status wait", {8'h00, v[7:0] & 8'h88}, {8'h00, val});
	endtask : wait_status
	task automatic send_sector(input logic [15:0] base, input bit slow);
		for (int i = 0; i < 256; i++) begin
			@(negedge core_clk_in) host = '{1'b1, 1'b0, 3'h0, base + 16'(i)};
			exp_sum += 32'(base + 16'(i));
			if (slow) @(negedge core_clk_in) host.wr = 1'b0;
		end
		@(negedge core_clk_in) host.wr = 1'b0;
	endtask : send_sector
	task automatic smart(input logic [7:0] feat, input logic abort);
		issue(8'hb0, feat, 8'h00, 8'he0, 8'hc2, 8'h4f, 8'h00);
		repeat (4) @(negedge core_clk_in);
		rd(3'h7, v);
		if (v[3] === 1'b1) begin
			repeat (256) begin
				rd(3'h0, v);
				check("smart word", v, 16'h5a3c);
			end
			rd(3'h7, v);
		end
		check("smart status", {8'h00, v[7:0] & 8'h89}, {15'h0, abort});
		rd(3'h1, v);
		check("abort bit", {15'h0, v[2]}, {15'h0, abort});
	endtask : smart
	task automatic do_reset;
		rst_n_in = 1'b0;
		repeat (4) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		repeat (4) @(negedge core_clk_in);
	endtask : do_reset
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	// ----
	// Test sequence
	// ----
	initial begin
		host = '0;
		{nv_en, stall, exp_sum, fail_at} = {2'b00, 32'h0, 10'h3ff};
		do_reset();
		rd(3'h7, v);
		check("reset status", {8'h00, v[7:0] & 8'hc9}, 16'h0040);
		rd(3'h6, v);
		check("reset drive head", {8'h00, v[7:0]}, 16'h00a0);
		// Two slow sectors, stalling flash, no prior erase.
		stall = 1'b1;
		i0 = irqs;
		issue(8'h38, 8'h00, 8'h02, 8'he5, 8'h12, 8'h34, 8'h56);
		for (int s = 0; s < 2; s++) begin
			wait_status(8'h08);
			send_sector(16'(s) << 12, 1'b1);
		end
		wait_status(8'h00);
		check("request count", {6'h0, reqs}, 16'h0002);
		check("last lba low", last.lba[15:0], 16'h3457);
		check("last lba high", last.lba[27:16], 16'h0512);
		check("write flags", {14'h0, last.verify, last.no_erase}, 16'h0001);
		check("data sum", sum[15:0], exp_sum[15:0]);
		check("sector irqs", 16'(irqs - i0), 16'h0002);
		rd(3'h3, v);
		check("lba after write", {8'h00, v[7:0]}, 16'h0058);
		// Verified write whose second sector fails.
		stall = 1'b0;
		fail_at = reqs + 10'd2;
		issue(8'h3c, 8'h00, 8'h03, 8'he0, 8'h00, 8'h00, 8'h10);
		for (int s = 0; s < 2; s++) begin
			wait_status(8'h08);
			send_sector(16'h3000, 1'b0);
		end
		wait_status(8'h00);
		check("verify flags", {14'h0, last.verify, last.no_erase}, 16'h0002);
		rd(3'h7, v);
		check("error status", {8'h00, v[7:0] & 8'h89}, 16'h0001);
		rd(3'h3, v);
		check("failing lba", {8'h00, v[7:0]}, 16'h0011);
		rd(3'h2, v);
		check("residual count", {8'h00, v[7:0]}, 16'h0002);
		fail_at = 10'h3ff;
		// Every feature code.
		for (int k = 0; k < 10; k++) begin
			smart(feats[k], aborts[k]);
			if (k == 2 || k == 8) check("stored enable", {15'h0, nv_out}, {15'h0, k == 2});
		end
		// Stored enable survives reset.
		nv_en = 1'b1;
		do_reset();
		smart(8'hd0, 1'b0);
		// A zero count moves 256 sectors.
		q0 = int'(reqs);
		issue(8'h38, 8'h00, 8'h00, 8'he0, 8'h00, 8'h00, 8'h20);
		repeat (256) begin
			wait_status(8'h08);
			send_sector(16'h0100, 1'b0);
		end
		wait_status(8'h00);
		check("full count", 16'(int'(reqs) - q0), 16'h0100);
		rd(3'h4, v);
		check("full lba mid", {8'h00, v[7:0]}, 16'h0001);
		report_and_stop();
	end
endmodule : ata_write_and_smart_commands_tb
